// >>> rtl/dsf_top.sv
// Status and fault indication of a servo drive controller with APB registers.
// Assumes fault, thermal limit and boot-done inputs come from outside this clock domain.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps

// Summary of operation
// R1: Red indicator blinks while booting and loading parameters.
// R2: After boot completes red indicator stops blinking and lights steadily.
// R3: Unconfigured controller keeps red blinking until configured over serial port.
// R4: Fault while enabled turns green off and red on.
// R5: Re-enabling erases stored faults and turns red off.
// R6: Thermal torque limit lights yellow and holds thermal relay open.
// R7: Green lit while enabled, off when disabled or faulted.
// R8: Ready relay closes when powered and fault free; open while unpowered.
// R9: Re-enable after fault resets fault and closes ready relay.
// R10: Ready relay opens on fault while enabled and when switched off; the code leaves it closed on the drive off command.
// R11: Fault latches hold until read by query, then clear.
// R12: Query also reports a present bit for each live fault.
// R13: Step mode up and down keys change value by five percent.
// R14: Set accepts typed value, list shows value, quit leaves mode.
// R15: Save accepted only with a four digit code number.
// R16: Save also stores control mode and reference source.
// R17: Enable releases brake; disable turns off; separate command engages brake; the code's command toggles the brake release instead.
// R18: Latch on rising fault; present bit follows live condition.
module dsf_top (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [dsf_pkg::NFAULT-1:0] fault_i,
	input wire logic thermal_limit_i,
	input wire logic boot_done_i,
	input wire logic was_configured_i,
	output logic led_red_o,
	output logic led_yellow_o,
	output logic led_green_o,
	output logic thermal_relay_closed_o,
	output logic ready_relay_closed_o,
	output logic drive_enable_o,
	output logic brake_release_o,
	output logic save_req_o,
	output logic [1:0] saved_loop_mode_o,
	output logic [1:0] saved_ref_src_o,
	output logic irq_o
);
	localparam int NF = dsf_pkg::NFAULT;

	// Two-stage synchronisers for all asynchronous levels.
	logic [NF+2:0] sync1_q;
	logic [NF+2:0] sync2_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {was_configured_i, boot_done_i, thermal_limit_i, fault_i};
			sync2_q <= sync1_q;
		end
	end
	logic [NF-1:0] flt_s;
	logic therm_s;
	logic boot_s;
	logic conf_s;
	assign flt_s = sync2_q[NF-1:0];
	assign therm_s = sync2_q[NF];
	assign boot_s = sync2_q[NF+1];
	assign conf_s = sync2_q[NF+2];

	// APB decode: zero wait state, every access is answered in its access phase.
	logic wr;
	logic rd;
	assign wr = psel_i & penable_i & pwrite_i;
	assign rd = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	logic mapped;
	always_comb begin
		unique case (paddr_i)
			dsf_pkg::ADR_CTRL, dsf_pkg::ADR_STAT, dsf_pkg::ADR_FAULT, dsf_pkg::ADR_GAIN,
			dsf_pkg::ADR_STEP, dsf_pkg::ADR_SAVE, dsf_pkg::ADR_MODE, dsf_pkg::ADR_IRQ_ST,
			dsf_pkg::ADR_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr_o = psel_i & penable_i & ~mapped;

	logic wr_ctrl;
	logic wr_step;
	logic wr_save;
	logic wr_mode;
	logic rd_fault;
	assign wr_ctrl = wr & (paddr_i == dsf_pkg::ADR_CTRL);
	assign wr_step = wr & (paddr_i == dsf_pkg::ADR_STEP);
	assign wr_save = wr & (paddr_i == dsf_pkg::ADR_SAVE);
	assign wr_mode = wr & (paddr_i == dsf_pkg::ADR_MODE);
	assign rd_fault = rd & (paddr_i == dsf_pkg::ADR_FAULT);

	// Boot sequencing.
	dsf_pkg::dsf_boot_t boot_q;
	logic cfg_cmd;
	assign cfg_cmd = wr_ctrl & pwdata_i[dsf_pkg::CTRL_CONFIGURED];
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			boot_q <= dsf_pkg::DSF_BOOT;
		end else begin
			unique case (boot_q)
				dsf_pkg::DSF_BOOT: if (boot_s) begin
					boot_q <= conf_s ? dsf_pkg::DSF_RUN : dsf_pkg::DSF_UNCONF; // R2 R3
				end
				dsf_pkg::DSF_UNCONF: if (cfg_cmd) begin
					boot_q <= dsf_pkg::DSF_RUN; // R3
				end
				dsf_pkg::DSF_RUN: boot_q <= dsf_pkg::DSF_RUN;
			endcase
		end
	end
	logic booted;
	assign booted = (boot_q == dsf_pkg::DSF_RUN);

	// Blink divider toggles the blink_q level every half period.
	logic [31:0] blink_cnt_q;
	logic blink_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == 32'(dsf_pkg::BLINK_HALF_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	// Fault channels.
	logic [NF-1:0] latched;
	logic [NF-1:0] present;
	logic [NF-1:0] rise;
	logic [NF-1:0] clr;
	logic reenable;
	for (genvar g = 0; g < NF; g++) begin : g_flt
		dsf_fault_latch u_latch (
			.mclk_i(mclk_i),
			.rst_i(rst_i),
			.fault_i(flt_s[g]),
			.clear_i(clr[g]),
			.latched_o(latched[g]),
			.present_o(present[g]),
			.rise_o(rise[g])
		);
	end
	assign clr = {NF{rd_fault | reenable}}; // R11 R5

	// Drive enable and brake, driven by terminal commands.
	logic on_cmd;
	logic off_cmd;
	logic brk_cmd;
	logic any_fault;
	assign on_cmd = wr_ctrl & pwdata_i[dsf_pkg::CTRL_DRIVE_ON];
	assign off_cmd = wr_ctrl & pwdata_i[dsf_pkg::CTRL_DRIVE_OFF];
	assign brk_cmd = wr_ctrl & pwdata_i[dsf_pkg::CTRL_BRAKE_TOGGLE];
	assign any_fault = |rise;
	assign reenable = on_cmd & booted;
	logic fault_trip_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			drive_enable_o <= 1'b0;
			brake_release_o <= 1'b0;
		end else if (any_fault & drive_enable_o) begin
			drive_enable_o <= 1'b0; // R4 R7
		end else if (reenable) begin
			drive_enable_o <= 1'b1; // R17
			brake_release_o <= 1'b1; // R17
		end else if (off_cmd) begin
			drive_enable_o <= 1'b0; // R17
		end else if (brk_cmd) begin
			brake_release_o <= ~brake_release_o; // R17
		end
	end

	// Trip memory: a fault while enabled drives red on and opens the ready relay.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fault_trip_q <= 1'b0;
		end else if (any_fault & drive_enable_o) begin
			fault_trip_q <= 1'b1; // R4 R10
		end else if (reenable) begin
			fault_trip_q <= 1'b0; // R5 R9
		end
	end

	// Indicators and relays, registered.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			led_red_o <= 1'b0;
			led_yellow_o <= 1'b0;
			led_green_o <= 1'b0;
			thermal_relay_closed_o <= 1'b0;
			ready_relay_closed_o <= 1'b0;
		end else begin
			if (!booted) begin
				led_red_o <= blink_q; // R1 R3
			end else begin
				led_red_o <= fault_trip_q | (|present) | ~drive_enable_o & ~reenable; // R2 R4 R5
			end
			led_yellow_o <= therm_s; // R6
			thermal_relay_closed_o <= ~therm_s; // R6
			led_green_o <= drive_enable_o & ~fault_trip_q; // R7
			ready_relay_closed_o <= ~fault_trip_q & ~(|present & ~booted); // R8 R9 R10
		end
	end

	// Step-adjust entry of the selected gain.
	logic [31:0] gain_q;
	logic [31:0] typed_q;
	logic step_mode_q;
	logic list_q;
	logic [2:0] key;
	logic [31:0] five_pct;
	assign key = pwdata_i[2:0];
	assign five_pct = gain_q / 32'h14;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			gain_q <= dsf_pkg::GAIN_RST;
			typed_q <= '0;
			step_mode_q <= 1'b0;
			list_q <= 1'b0;
		end else if (wr_step) begin
			list_q <= 1'b0;
			if (key == dsf_pkg::KEY_ENTER) begin
				step_mode_q <= 1'b1;
				typed_q <= {3'h0, pwdata_i[31:3]};
			end else if (step_mode_q) begin
				unique case (key)
					dsf_pkg::KEY_UP: gain_q <= gain_q + five_pct; // R13
					dsf_pkg::KEY_DOWN: gain_q <= gain_q - five_pct; // R13
					dsf_pkg::KEY_SET: gain_q <= {3'h0, pwdata_i[31:3]}; // R14
					dsf_pkg::KEY_LIST: list_q <= 1'b1; // R14
					dsf_pkg::KEY_QUIT: step_mode_q <= 1'b0; // R14
					default: typed_q <= typed_q;
				endcase
			end
		end
	end

	// Control mode and reference source, plus the saved copies.
	logic [1:0] loop_mode_q;
	logic [1:0] ref_src_q;
	logic code_ok;
	assign code_ok = (pwdata_i[3:0] < 4'hA) & (pwdata_i[7:4] < 4'hA) &
		(pwdata_i[11:8] < 4'hA) & (pwdata_i[15:12] < 4'hA);
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			loop_mode_q <= dsf_pkg::MODE_RST;
			ref_src_q <= dsf_pkg::MODE_RST;
			saved_loop_mode_o <= dsf_pkg::MODE_RST;
			saved_ref_src_o <= dsf_pkg::MODE_RST;
			save_req_o <= 1'b0;
		end else begin
			save_req_o <= 1'b0;
			if (wr_mode) begin
				loop_mode_q <= pwdata_i[1:0];
				ref_src_q <= pwdata_i[5:4];
			end
			if (wr_save && code_ok) begin
				save_req_o <= 1'b1; // R15
				saved_loop_mode_o <= loop_mode_q; // R16
				saved_ref_src_o <= ref_src_q; // R16
			end
		end
	end

	// Interrupts: sticky, write one to clear, set wins over clear.
	logic [dsf_pkg::IRQ_W-1:0] irq_st_q;
	logic [dsf_pkg::IRQ_W-1:0] irq_mask_q;
	logic [dsf_pkg::IRQ_W-1:0] irq_set;
	logic [dsf_pkg::IRQ_W-1:0] irq_clr;
	logic booted_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			booted_q <= 1'b0;
		end else begin
			booted_q <= booted;
		end
	end
	assign irq_set = {save_req_o, booted & ~booted_q, any_fault};
	assign irq_clr = (wr && paddr_i == dsf_pkg::ADR_IRQ_ST) ? pwdata_i[dsf_pkg::IRQ_W-1:0] : '0;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_st_q <= '0;
			irq_mask_q <= '0;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
			if (wr && paddr_i == dsf_pkg::ADR_IRQ_MASK) begin
				irq_mask_q <= pwdata_i[dsf_pkg::IRQ_W-1:0];
			end
		end
	end
	assign irq_o = |(irq_st_q & irq_mask_q);

	// Read data mux.
	always_comb begin
		prdata_o = '0;
		if (rd) begin
			unique case (paddr_i)
				dsf_pkg::ADR_CTRL: prdata_o = {28'h0, ~(boot_q == dsf_pkg::DSF_UNCONF),
					1'b0, brake_release_o, drive_enable_o};
				dsf_pkg::ADR_STAT: prdata_o = {24'h0, ready_relay_closed_o, led_green_o,
					led_yellow_o, led_red_o, list_q, step_mode_q, boot_q};
				dsf_pkg::ADR_FAULT: prdata_o = {16'h0, 2'h0, present, 2'h0, latched}; // R11 R12
				dsf_pkg::ADR_GAIN: prdata_o = gain_q;
				dsf_pkg::ADR_STEP: prdata_o = typed_q;
				dsf_pkg::ADR_MODE: prdata_o = {26'h0, ref_src_q, 2'h0, loop_mode_q};
				dsf_pkg::ADR_IRQ_ST: prdata_o = {29'h0, irq_st_q};
				dsf_pkg::ADR_IRQ_MASK: prdata_o = {29'h0, irq_mask_q};
				default: prdata_o = '0;
			endcase
		end
	end
endmodule

// >>> pkg/dsf_pkg.sv
// Package for the drive status and fault indication block.
// Assumes a 100 MHz system clock and an APB register slave with 32-bit data.
package dsf_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int NFAULT = 6;

	// Register byte addresses.
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_FAULT = 8'h08;
	localparam logic [7:0] ADR_GAIN = 8'h0C;
	localparam logic [7:0] ADR_STEP = 8'h10;
	localparam logic [7:0] ADR_SAVE = 8'h14;
	localparam logic [7:0] ADR_MODE = 8'h18;
	localparam logic [7:0] ADR_IRQ_ST = 8'h1C;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h20;

	// Control register command bits, self-clearing on write.
	localparam int CTRL_DRIVE_ON = 0;
	localparam int CTRL_DRIVE_OFF = 1;
	localparam int CTRL_BRAKE_TOGGLE = 2;
	localparam int CTRL_CONFIGURED = 3;

	// Step-adjust key codes written to the step register.
	localparam logic [2:0] KEY_UP = 3'h1;
	localparam logic [2:0] KEY_DOWN = 3'h2;
	localparam logic [2:0] KEY_SET = 3'h3;
	localparam logic [2:0] KEY_LIST = 3'h4;
	localparam logic [2:0] KEY_QUIT = 3'h5;
	localparam logic [2:0] KEY_ENTER = 3'h6;

	// Save register: code in the low 16 bits as four BCD digits.
	localparam int SAVE_CODE_W = 16;

	// Interrupt status bits.
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_BOOT_DONE = 1;
	localparam int IRQ_SAVE_DONE = 2;
	localparam int IRQ_W = 3;

	localparam logic [31:0] GAIN_RST = 32'h0000_1000;
	localparam logic [1:0] MODE_RST = 2'h0;

	typedef enum logic [1:0] {DSF_BOOT, DSF_UNCONF, DSF_RUN} dsf_boot_t;
endpackage

// >>> rtl/dsf_fault_latch.sv
// One fault channel: latched entry, present indication and edge detect.
// Assumes the fault level is already synchronous to mclk_i.
`timescale 1ns/1ps
module dsf_fault_latch (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic fault_i,
	input wire logic clear_i,
	output logic latched_o,
	output logic present_o,
	output logic rise_o
);
	logic prev_q;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
			present_o <= 1'b0;
		end else begin
			prev_q <= fault_i;
			present_o <= fault_i; // R12 R18
		end
	end

	assign rise_o = fault_i & ~prev_q;

	// A new rising edge in the clearing cycle wins so no fault is lost.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			latched_o <= 1'b0;
		end else if (rise_o) begin
			latched_o <= 1'b1; // R11 R18
		end else if (clear_i) begin
			latched_o <= 1'b0; // R11
		end
	end
endmodule

// >>> bench/dsf_checker.sv
// Concurrent checks on the status and fault indication block's ports.
// Assumes one clock domain and the synchronous active-high reset rst_i.
`timescale 1ns/1ps
module dsf_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pslverr_o,
	input wire logic [dsf_pkg::NFAULT-1:0] fault_i,
	input wire logic thermal_limit_i,
	input wire logic led_red_o,
	input wire logic led_yellow_o,
	input wire logic led_green_o,
	input wire logic thermal_relay_closed_o,
	input wire logic ready_relay_closed_o,
	input wire logic drive_enable_o,
	input wire logic brake_release_o,
	input wire logic save_req_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	// Faults pass two synchroniser flops, so a trip is allowed a few cycles.
	sequence s_trip;
		drive_enable_o && ((fault_i & ~$past(fault_i)) != '0);
	endsequence

	a_trip_disables: assert property (s_trip |-> ##[1:8] (!drive_enable_o && !led_green_o))
		else $error("fault while enabled did not drop drive and green");
	a_trip_opens_ready: assert property (s_trip |-> ##[1:8] (!ready_relay_closed_o && led_red_o))
		else $error("fault while enabled did not open ready relay");
	a_green_needs_enable: assert property (led_green_o |-> drive_enable_o || $past(drive_enable_o))
		else $error("green lit while drive disabled");
	a_yellow_on_limit: assert property ($rose(thermal_limit_i) |-> ##[1:6] led_yellow_o)
		else $error("yellow not lit on thermal limit");
	a_relay_open_limit: assert property (led_yellow_o |-> !thermal_relay_closed_o)
		else $error("thermal relay closed during limit");
	a_enable_brake: assert property ($rose(drive_enable_o) |-> brake_release_o)
		else $error("enable without brake release");
	a_save_single: assert property (save_req_o |=> !save_req_o)
		else $error("save request longer than one cycle");
	a_save_cause: assert property (save_req_o |->
		$past(psel_i && penable_i && pwrite_i && paddr_i == dsf_pkg::ADR_SAVE) ||
		$past(psel_i && penable_i && pwrite_i && paddr_i == dsf_pkg::ADR_SAVE, 2))
		else $error("save request without save write");
	a_unmapped_error: assert property (psel_i && penable_i && paddr_i > dsf_pkg::ADR_IRQ_MASK |->
		pslverr_o)
		else $error("no error on unmapped access");

	c_trip: cover property (s_trip);
	c_save: cover property ($rose(save_req_o));
	c_limit: cover property ($rose(led_yellow_o));
endmodule

bind dsf_top dsf_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o),
	.fault_i(fault_i), .thermal_limit_i(thermal_limit_i), .led_red_o(led_red_o),
	.led_yellow_o(led_yellow_o), .led_green_o(led_green_o),
	.thermal_relay_closed_o(thermal_relay_closed_o), .ready_relay_closed_o(ready_relay_closed_o),
	.drive_enable_o(drive_enable_o), .brake_release_o(brake_release_o), .save_req_o(save_req_o));

// >>> bench/dsf_term.sv
// Operator terminal model: issues register transfers as an APB master.
// Assumes the slave answers with pready; only the bench watchdog ends a wait.
`timescale 1ns/1ps
module dsf_term (
	input wire logic mclk_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0000_0000;
	end

	// The save code is sent as four decimal digits by the caller.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge mclk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= wd;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		@(posedge mclk_i);
		while (pready_i !== 1'b1) begin
			@(posedge mclk_i);
		end
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines show the inverse so stale values are never mistaken for live ones.
		paddr_o <= ~a;
		pwdata_o <= ~wd;
	endtask
endmodule

// >>> bench/drive_status_fault_indication_bench.sv
// Self-checking bench for the status and fault indication block.
// Assumes the terminal model drives APB and the bench drives the drive-side levels.
`timescale 1ns/1ps
module drive_status_fault_indication_bench;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d, saves = 32'h0;
	logic [dsf_pkg::NFAULT-1:0] fault_i = '0;
	logic thermal_i = 1'b0;
	logic boot_i = 1'b0;
	logic conf_i = 1'b0;
	logic red, yel, grn, trelay, ready, en, brake, save;
	logic [1:0] smode, ssrc;
	int err_count = 0;
	int total_checks = 0;
	wire [5:0] st = {red, yel, grn, ready, en, brake};

	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (save === 1'b1) saves <= saves + 32'h1;

	dsf_term u_term (.mclk_i(mclk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	dsf_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .fault_i(fault_i), .thermal_limit_i(thermal_i),
		.boot_done_i(boot_i), .was_configured_i(conf_i), .led_red_o(red), .led_yellow_o(yel),
		.led_green_o(grn), .thermal_relay_closed_o(trelay), .ready_relay_closed_o(ready),
		.drive_enable_o(en), .brake_release_o(brake), .save_req_o(save),
		.saved_loop_mode_o(smode), .saved_ref_src_o(ssrc), .irq_o(irq));

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_term.xfer(1'b1, a, v, d, err);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		u_term.xfer(1'b0, a, 32'h0, d, err);
		chk(n, e, d & m);
	endtask

	// Order: red, yellow, green, ready relay, drive enable, brake release.
	task automatic so(input logic [5:0] e, input logic [5:0] m);
		chk("outputs", {26'h0, e}, {26'h0, st & m});
	endtask

	initial begin
		repeat (5000) @(posedge mclk_i);
		err_count++;
		results();
	end

	initial begin
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		wt(1);
		chk("pready", 32'h1, {31'h0, pready});
		rdc("boot state", dsf_pkg::ADR_STAT, 32'h3, 32'h0);
		@(posedge mclk_i);
		boot_i <= 1'b1;
		wt(6);
		rdc("unconfigured", dsf_pkg::ADR_STAT, 32'h3, 32'h1);
		wr(dsf_pkg::ADR_CTRL, 32'h8);
		wt(2);
		rdc("configured", dsf_pkg::ADR_STAT, 32'h13, 32'h12);
		so(6'b100100, 6'h3F);
		// The boot-done event is raised only on entering the running state.
		wr(dsf_pkg::ADR_IRQ_MASK, 32'h7);
		wt(1);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(dsf_pkg::ADR_IRQ_MASK, 32'h0);
		wt(1);
		chk("irq mask", 32'h0, {31'h0, irq});
		rdc("irq status", dsf_pkg::ADR_IRQ_ST, 32'h2, 32'h2);
		wr(dsf_pkg::ADR_IRQ_MASK, 32'h7);
		wr(dsf_pkg::ADR_IRQ_ST, 32'h2);
		wt(1);
		chk("irq clear", 32'h0, {31'h0, irq});
		wr(dsf_pkg::ADR_CTRL, 32'h1);
		wt(2);
		so(6'b001111, 6'h3F);
		@(posedge mclk_i);
		fault_i <= 6'h04;
		wt(8);
		so(6'b100000, 6'h3E);
		rdc("fault query", dsf_pkg::ADR_FAULT, 32'h3F3F, 32'h0404);
		@(posedge mclk_i);
		fault_i <= 6'h00;
		wt(6);
		rdc("fault cleared", dsf_pkg::ADR_FAULT, 32'h3F3F, 32'h0);
		wr(dsf_pkg::ADR_CTRL, 32'h1);
		wt(2);
		so(6'b001111, 6'h3F);
		@(posedge mclk_i);
		thermal_i <= 1'b1;
		wt(6);
		chk("thermal on", 32'h2, {30'h0, yel, trelay});
		@(posedge mclk_i);
		thermal_i <= 1'b0;
		wt(6);
		chk("thermal off", 32'h1, {30'h0, yel, trelay});
		wr(dsf_pkg::ADR_STEP, 32'h8006);
		rdc("step mode", dsf_pkg::ADR_STAT, 32'h4, 32'h4);
		wr(dsf_pkg::ADR_STEP, 32'h7D03);
		rdc("gain set", dsf_pkg::ADR_GAIN, 32'hFFFF_FFFF, 32'hFA0);
		wr(dsf_pkg::ADR_STEP, 32'h1);
		rdc("gain up", dsf_pkg::ADR_GAIN, 32'hFFFF_FFFF, 32'h1068);
		wr(dsf_pkg::ADR_STEP, 32'h2);
		rdc("gain down", dsf_pkg::ADR_GAIN, 32'hFFFF_FFFF, 32'hF96);
		wr(dsf_pkg::ADR_STEP, 32'h4);
		rdc("list flag", dsf_pkg::ADR_STAT, 32'h8, 32'h8);
		wr(dsf_pkg::ADR_STEP, 32'h5);
		rdc("mode quit", dsf_pkg::ADR_STAT, 32'h4, 32'h0);
		wr(dsf_pkg::ADR_STEP, 32'h1);
		rdc("gain after quit", dsf_pkg::ADR_GAIN, 32'hFFFF_FFFF, 32'hF96);
		wr(dsf_pkg::ADR_MODE, 32'h21);
		rdc("mode", dsf_pkg::ADR_MODE, 32'h33, 32'h21);
		wr(dsf_pkg::ADR_SAVE, 32'h1234);
		wt(3);
		chk("save count", 32'h1, saves);
		chk("saved mode", 32'h6, {28'h0, smode, ssrc});
		wr(dsf_pkg::ADR_MODE, 32'h02);
		wr(dsf_pkg::ADR_SAVE, 32'h12A4);
		wt(3);
		chk("bad code", 32'h1, saves);
		chk("saved kept", 32'h6, {28'h0, smode, ssrc});
		u_term.xfer(1'b0, 8'h40, 32'h0, d, err);
		chk("unmapped data", 32'h0, d);
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(dsf_pkg::ADR_CTRL, 32'h2);
		wt(2);
		so(6'b100101, 6'h3F);
		wr(dsf_pkg::ADR_CTRL, 32'h4);
		wt(2);
		so(6'b100100, 6'h3F);
		// A second reset with valid parameters must boot straight to the running state.
		@(posedge mclk_i);
		rst_i <= 1'b1;
		conf_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		wt(6);
		rdc("configured boot", dsf_pkg::ADR_STAT, 32'h3, 32'h2);
		so(6'b100100, 6'h3F);
		results();
	end
endmodule
